// ### rtl/addr_map_defs.vh
// Address map constants for program and data memory decoding
`ifndef ADDR_MAP_DEFS_VH
`define ADDR_MAP_DEFS_VH

`define RESET_START_ADDR 12'h000
`define CALL_PAGE_LO 12'h010
`define CALL_PAGE_HI 12'h01F
`define IRQ_VEC_LO 12'h020
`define IRQ_VEC_HI 12'h03D
`define USER_TOP_ADDR 12'hFDF
`define BANK_RAM 3'h7
`define BANK_PERIPH 3'h0
`define PERIPH_LIMIT 8'h80
`define STACK_TOP 8'hFF
`define STACK_FLOOR 8'h80
`define CALL_FRAME 8'h04
`define IRQ_FRAME 8'h08
`define NIBBLE_ONES 4'hF
`define IRQ_VEC_COUNT 4'hF

`endif

// ### rtl/nibble_ram.v
// Bank 7 data RAM, 256 nibbles held in flip-flops
module nibble_ram (
  input wire mclk,
  input wire rst,
  input wire we,
  input wire [7:0] waddr,
  input wire [3:0] wdata,
  input wire [7:0] raddr,
  output reg [3:0] rdata
);

  reg [3:0] mem [0:255];
  integer i;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < 256; i = i + 1) begin
        mem[i] <= 4'h0;
      end
      rdata <= 4'h0;
    end else begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end

endmodule // nibble_ram

// ### rtl/address_map_decoder.v
// Program and data address decoder with stack pointer for a 4-bit core
`include "addr_map_defs.vh"

module address_map_decoder (
  input wire mclk,
  input wire rst,
  input wire fetch_req,
  input wire [11:0] fetch_addr,
  input wire call_page_req,
  input wire [3:0] call_page_idx,
  input wire irq_req,
  input wire [3:0] irq_src,
  output reg [11:0] pc_r,
  output reg fetch_valid_r,
  output reg call_page_hit_r,
  output reg irq_vec_hit_r,
  output reg test_area_r,
  input wire data_req,
  input wire data_we,
  input wire [2:0] data_bank,
  input wire [7:0] data_addr,
  input wire [3:0] data_wdata,
  output reg [3:0] data_rdata_r,
  output reg data_ack_r,
  output reg ram_sel_r,
  output reg periph_sel_r,
  output reg periph_we_r,
  output reg [6:0] periph_addr_r,
  output reg [3:0] periph_wdata_r,
  input wire [3:0] periph_rdata,
  input wire push_call,
  input wire push_irq,
  input wire pop_call,
  input wire pop_irq,
  output reg [7:0] sp_r,
  output reg stack_fault_r
);

  // ****************************************
  // Decode helpers
  // ****************************************
  function in_range;
    input [11:0] a;
    input [11:0] lo;
    input [11:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  function is_ram;
    input [2:0] b;
    begin
      is_ram = (b == `BANK_RAM);
    end
  endfunction

  function is_periph;
    input [2:0] b;
    input [7:0] a;
    begin
      is_periph = (b == `BANK_PERIPH) && (a < `PERIPH_LIMIT);
    end
  endfunction

  // Region codes of a data access
  localparam REGION_NONE = 2'b00;
  localparam REGION_RAM = 2'b01;
  localparam REGION_PERIPH = 2'b10;

  function [1:0] region_of;
    input [2:0] b;
    input [7:0] a;
    begin
      if (is_ram(b)) begin
        region_of = REGION_RAM;
      end else if (is_periph(b, a)) begin
        region_of = REGION_PERIPH;
      end else begin
        region_of = REGION_NONE;
      end
    end
  endfunction

  // True when a frame of f nibbles fits in the count c
  function fits;
    input [8:0] c;
    input [7:0] f;
    begin
      fits = (c >= {1'b0, f});
    end
  endfunction

  // ****************************************
  // Program side
  // ****************************************
  reg [11:0] pc_nxt;
  reg fetch_ok;
  reg call_page_hit_nxt;
  reg irq_vec_hit_nxt;
  reg test_area_nxt;

  always @* begin
    pc_nxt = pc_r;
    fetch_ok = 1'b0;
    if (irq_req) begin
      // Two vector bytes per source; source 15 would land on 03E, so it is pulled back to 03C inside 020..03D
      pc_nxt = `IRQ_VEC_LO + {7'h00, irq_src, 1'b0};
      if (irq_src == `IRQ_VEC_COUNT) begin
        pc_nxt = `IRQ_VEC_HI - 12'h001;
      end
      fetch_ok = 1'b1;
    end else if (call_page_req) begin
      pc_nxt = `CALL_PAGE_LO + {8'h00, call_page_idx};
      fetch_ok = 1'b1;
    end else if (fetch_req) begin
      pc_nxt = fetch_addr;
      fetch_ok = (fetch_addr <= `USER_TOP_ADDR);
    end
  end

  // Hit flags describe the address accepted, not the one asked for
  always @* begin
    call_page_hit_nxt = fetch_ok && in_range(pc_nxt, `CALL_PAGE_LO, `CALL_PAGE_HI);
    irq_vec_hit_nxt = fetch_ok && in_range(pc_nxt, `IRQ_VEC_LO, `IRQ_VEC_HI);
    // Fetch into the test area is refused and flagged, pc holds
    test_area_nxt = fetch_req && !irq_req && !call_page_req
      && (fetch_addr > `USER_TOP_ADDR);
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pc_r <= `RESET_START_ADDR;
      fetch_valid_r <= 1'b0;
      call_page_hit_r <= 1'b0;
      irq_vec_hit_r <= 1'b0;
      test_area_r <= 1'b0;
    end else begin
      if (fetch_ok) begin
        pc_r <= pc_nxt;
      end
      fetch_valid_r <= fetch_ok;
      call_page_hit_r <= call_page_hit_nxt;
      irq_vec_hit_r <= irq_vec_hit_nxt;
      test_area_r <= test_area_nxt;
    end
  end

  // ****************************************
  // Stack pointer
  // ****************************************
  reg [7:0] sp_nxt;
  reg fault_nxt;
  wire [8:0] room = {1'b0, sp_r} - {1'b0, `STACK_FLOOR} + 9'h001;
  wire [8:0] used = {1'b0, `STACK_TOP} - {1'b0, sp_r};

  always @* begin
    sp_nxt = sp_r;
    fault_nxt = 1'b0;
    // Overflow past the RAM half is refused rather than wrapping
    if (push_irq) begin
      if (fits(room, `IRQ_FRAME)) begin
        sp_nxt = sp_r - `IRQ_FRAME;
      end else begin
        fault_nxt = 1'b1;
      end
    end else if (push_call) begin
      if (fits(room, `CALL_FRAME)) begin
        sp_nxt = sp_r - `CALL_FRAME;
      end else begin
        fault_nxt = 1'b1;
      end
    end else if (pop_irq) begin
      if (fits(used, `IRQ_FRAME)) begin
        sp_nxt = sp_r + `IRQ_FRAME;
      end else begin
        fault_nxt = 1'b1;
      end
    end else if (pop_call) begin
      if (fits(used, `CALL_FRAME)) begin
        sp_nxt = sp_r + `CALL_FRAME;
      end else begin
        fault_nxt = 1'b1;
      end
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sp_r <= `STACK_TOP;
      stack_fault_r <= 1'b0;
    end else begin
      sp_r <= sp_nxt;
      stack_fault_r <= fault_nxt;
    end
  end

  // ****************************************
  // Data side
  // ****************************************
  reg [1:0] region;
  reg ram_hit;
  reg per_hit;
  reg miss_hit;
  wire [3:0] ram_q;
  reg ram_rd_r;
  reg per_rd_r;
  reg miss_rd_r;

  // Bank number picks the region first, the in-bank address only matters in bank 0
  always @* begin
    region = region_of(data_bank, data_addr);
    ram_hit = 1'b0;
    per_hit = 1'b0;
    miss_hit = 1'b0;
    if (data_req) begin
      case (region)
        REGION_RAM: begin
          ram_hit = 1'b1;
        end
        REGION_PERIPH: begin
          per_hit = 1'b1;
        end
        default: begin
          // Nothing is selected, so no state can change behind the access
          miss_hit = 1'b1;
        end
      endcase
    end
  end

  nibble_ram u_ram (
    .mclk(mclk),
    .rst(rst),
    .we(ram_hit && data_we),
    .waddr(data_addr),
    .wdata(data_wdata),
    .raddr(data_addr),
    .rdata(ram_q)
  );

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ram_sel_r <= 1'b0;
      periph_sel_r <= 1'b0;
      periph_we_r <= 1'b0;
      periph_addr_r <= 7'h00;
      periph_wdata_r <= 4'h0;
      ram_rd_r <= 1'b0;
      per_rd_r <= 1'b0;
      miss_rd_r <= 1'b0;
    end else begin
      ram_sel_r <= ram_hit;
      periph_sel_r <= per_hit;
      periph_we_r <= per_hit && data_we;
      if (per_hit) begin
        periph_addr_r <= data_addr[6:0];
        periph_wdata_r <= data_wdata;
      end
      ram_rd_r <= ram_hit && !data_we;
      per_rd_r <= per_hit && !data_we;
      miss_rd_r <= miss_hit && !data_we;
    end
  end

  // ****************************************
  // Answer stage
  // ****************************************
  reg [3:0] data_rdata_nxt;
  reg data_ack_nxt;

  // Answer one cycle after the request stage, after peripheral replies
  always @* begin
    data_ack_nxt = ram_sel_r || periph_sel_r || ram_rd_r || per_rd_r || miss_rd_r;
    // Unmapped reads see all ones so a stray pointer reads as erased
    data_rdata_nxt = `NIBBLE_ONES;
    if (ram_rd_r) begin
      data_rdata_nxt = ram_q;
    end else if (per_rd_r) begin
      data_rdata_nxt = periph_rdata;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      data_rdata_r <= `NIBBLE_ONES;
      data_ack_r <= 1'b0;
    end else begin
      data_rdata_r <= data_rdata_nxt;
      data_ack_r <= data_ack_nxt;
    end
  end

endmodule // address_map_decoder

// ### testbench/address_map_decoder_asserts.sv
// Checker for program, data and stack decoding
module map_chk(
  input logic mclk,
  input logic rst,
  input logic fetch_req,
  input logic [11:0] fetch_addr,
  input logic call_page_req,
  input logic [3:0] call_page_idx,
  input logic irq_req,
  input logic [11:0] pc_r,
  input logic fetch_valid_r,
  input logic call_page_hit_r,
  input logic irq_vec_hit_r,
  input logic test_area_r,
  input logic data_req,
  input logic data_we,
  input logic [2:0] data_bank,
  input logic [7:0] data_addr,
  input logic [3:0] data_rdata_r,
  input logic data_ack_r,
  input logic ram_sel_r,
  input logic periph_sel_r,
  input logic push_call,
  input logic push_irq,
  input logic [7:0] sp_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire fo = fetch_req && !call_page_req && !irq_req;
  wire b0 = data_bank == 3'h0;
  wire dead = !b0 && data_bank != 3'h7 || b0 && data_addr[7];
  start_pc_a: assert property ($fell(rst) |-> pc_r == 12'h000)
    else $error("pc not at start after reset");
  call_page_a: assert property (call_page_req && !irq_req |=> call_page_hit_r
    && pc_r == {8'h01, $past(call_page_idx)}) else $error("call page address wrong");
  irq_vec_a: assert property (irq_req |=> irq_vec_hit_r
    && pc_r >= 12'h020 && pc_r <= 12'h03D) else $error("vector outside range");
  test_area_a: assert property (fo && fetch_addr > 12'hFDF |=> test_area_r
    && !fetch_valid_r && $stable(pc_r)) else $error("test area fetch taken");
  user_fetch_a: assert property (fo && fetch_addr <= 12'hFDF |=> fetch_valid_r
    && pc_r == $past(fetch_addr)) else $error("user fetch lost");
  ram_bank_a: assert property (data_req && data_bank == 3'h7 |=> ram_sel_r
    && !periph_sel_r) else $error("bank 7 not ram");
  periph_bank_a: assert property (data_req && b0 && !data_addr[7] |=> periph_sel_r
    && !ram_sel_r) else $error("bank 0 not peripheral");
  dead_sel_a: assert property (data_req && dead |=> !ram_sel_r && !periph_sel_r)
    else $error("unmapped place selected");
  dead_read_a: assert property (data_req && !data_we && dead |-> ##2 data_ack_r
    && data_rdata_r == 4'hF) else $error("unmapped read not ones");
  call_push_a: assert property (push_call && !push_irq && sp_r >= 8'h90
    |=> sp_r == $past(sp_r) - 8'h04) else $error("call push size");
  irq_push_a: assert property (push_irq && sp_r >= 8'h90
    |=> sp_r == $past(sp_r) - 8'h08) else $error("irq push size");
endmodule // map_chk

bind address_map_decoder map_chk u_chk(.*);

// ### testbench/periph_model.sv
// Peripheral side answering bank 0 reads
module periph_model(
  input logic mclk,
  input logic periph_sel_r,
  input logic [6:0] periph_addr_r,
  output logic [3:0] periph_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] junk_r = 4'h0;
  // Unselected bus toggles so a stale sample never looks valid
  always @(posedge mclk) junk_r <= ~junk_r + 4'h3;
  assign periph_rdata = periph_sel_r ? periph_addr_r[3:0] ^ 4'h5 : junk_r;
endmodule // periph_model

// ### testbench/address_map_decoder_bench.sv
// Self-checking bench for the address map decoder
`define CK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module address_map_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst = 1, fetch_req = 0, call_page_req = 0, irq_req = 0;
  logic [11:0] fetch_addr = 0, pc_r;
  logic [3:0] call_page_idx = 0, irq_src = 0, data_wdata = 0, periph_rdata, r;
  logic data_req = 0, data_we = 0, push_call = 0, push_irq = 0, pop_call = 0;
  logic pop_irq = 0, fetch_valid_r, test_area_r, periph_sel_r;
  logic [2:0] data_bank = 0;
  logic [7:0] data_addr = 0, sp_r;
  logic [3:0] data_rdata_r;
  logic [6:0] periph_addr_r;
  logic data_ack_r, ram_sel_r, periph_we_r, stack_fault_r, ack;
  logic [3:0] periph_wdata_r;
  logic [2:0] sel;
  int error_cnt = 0, checked = 0, cyc = 0;
  address_map_decoder DUT(.mclk(mclk), .rst(rst), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .call_page_req(call_page_req), .call_page_idx(call_page_idx),
    .irq_req(irq_req), .irq_src(irq_src), .pc_r(pc_r), .fetch_valid_r(fetch_valid_r),
    .call_page_hit_r(), .irq_vec_hit_r(), .test_area_r(test_area_r), .data_req(data_req),
    .data_we(data_we), .data_bank(data_bank), .data_addr(data_addr),
    .data_wdata(data_wdata), .data_rdata_r(data_rdata_r), .data_ack_r(data_ack_r),
    .ram_sel_r(ram_sel_r), .periph_sel_r(periph_sel_r), .periph_we_r(periph_we_r),
    .periph_addr_r(periph_addr_r), .periph_wdata_r(periph_wdata_r),
    .periph_rdata(periph_rdata), .push_call(push_call),
    .push_irq(push_irq), .pop_call(pop_call), .pop_irq(pop_irq), .sp_r(sp_r),
    .stack_fault_r(stack_fault_r));
  periph_model cpu_periph(.mclk(mclk), .periph_sel_r(periph_sel_r),
    .periph_addr_r(periph_addr_r), .periph_rdata(periph_rdata));
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  task stop_test;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Cuts a hang short well past the roughly 120 cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 2000) begin
      error_cnt++;
      stop_test;
    end
  end
  task pg(input [2:0] k, input [11:0] a, input [3:0] i);
    @(posedge mclk);
    {irq_req, call_page_req, fetch_req} <= k;
    fetch_addr <= a;
    call_page_idx <= i;
    irq_src <= i;
    @(posedge mclk);
    {irq_req, call_page_req, fetch_req} <= 3'h0;
    #1;
  endtask
  task acc(input w, input [2:0] b, input [7:0] a, input [3:0] d);
    @(posedge mclk);
    {data_req, data_we, data_bank, data_addr, data_wdata} <= {1'b1, w, b, a, d};
    @(posedge mclk);
    data_req <= 1'b0;
    #1 sel = {ram_sel_r, periph_sel_r, periph_we_r};
    @(posedge mclk);
    #1 r = data_rdata_r;
    ack = data_ack_r;
  endtask
  task st(input [3:0] k);
    @(posedge mclk);
    {push_irq, push_call, pop_irq, pop_call} <= k;
    @(posedge mclk);
    {push_irq, push_call, pop_irq, pop_call} <= 4'h0;
    #1;
  endtask
  task t_reset;
    `CK(pc_r, 12'h000)
    `CK(sp_r, 8'hFF)
  endtask
  task t_prog;
    pg(3'h1, 12'hFDF, 4'h0);
    `CK({fetch_valid_r, pc_r}, {1'b1, 12'hFDF})
    pg(3'h1, 12'hFE0, 4'h0);
    `CK({test_area_r, fetch_valid_r, pc_r}, {2'b10, 12'hFDF})
    pg(3'h2, 12'h000, 4'hF);
    `CK(pc_r, 12'h01F)
    pg(3'h4, 12'h000, 4'h1);
    `CK(pc_r, 12'h022)
    pg(3'h4, 12'h000, 4'hF);
    `CK(pc_r, 12'h03C)
    pg(3'h7, 12'h100, 4'h2);
    `CK(pc_r, 12'h024)
  endtask
  task t_data;
    acc(1, 3'h7, 8'h55, 4'hA);
    `CK({sel, ack}, 4'b1001)
    acc(1, 3'h0, 8'h12, 4'hC);
    `CK({sel, ack, periph_wdata_r, periph_addr_r}, {4'b0111, 4'hC, 7'h12})
    acc(1, 3'h3, 8'h55, 4'h0);
    `CK({sel, ack}, 4'b0000)
    acc(1, 3'h0, 8'hD5, 4'h3);
    `CK({sel, ack, periph_wdata_r, periph_addr_r}, {4'b0000, 4'hC, 7'h12})
    acc(0, 3'h7, 8'h55, 4'h0);
    `CK({r, ack}, {4'hA, 1'b1})
    acc(0, 3'h0, 8'h12, 4'h0);
    `CK({r, sel, ack}, {4'h7, 4'b0101})
    acc(0, 3'h3, 8'h55, 4'h0);
    `CK({r, sel, ack}, {4'hF, 4'b0001})
    acc(0, 3'h0, 8'h80, 4'h0);
    `CK({r, sel, ack}, {4'hF, 4'b0001})
  endtask
  task t_stack;
    st(4'h1);
    `CK({stack_fault_r, sp_r}, {1'b1, 8'hFF})
    st(4'h4);
    `CK(sp_r, 8'hFB)
    st(4'h8);
    `CK(sp_r, 8'hF3)
    st(4'h2);
    `CK(sp_r, 8'hFB)
    st(4'h1);
    `CK({stack_fault_r, sp_r}, {1'b0, 8'hFF})
    repeat (16) st(4'h8);
    `CK(sp_r, 8'h7F)
    st(4'h4);
    `CK({stack_fault_r, sp_r}, {1'b1, 8'h7F})
    repeat (16) st(4'h2);
    `CK({stack_fault_r, sp_r}, {1'b0, 8'hFF})
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    t_reset;
    t_prog;
    t_data;
    t_stack;
    stop_test;
  end
endmodule // address_map_decoder_bench
